// ==== csp_defs.svh ====
// constants for the control and status pin block
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH

// serial command bytes (first byte of an spi frame)
`define CSP_CMD_READ     8'h0a
`define CSP_CMD_CLEAR    8'h0c

// level of the mode select pin that selects i2c
`define CSP_MODE_I2C     1'b1

// positions inside the synchroniser vector
`define CSP_SY_MODE      0
`define CSP_SY_DIS       1
`define CSP_SY_CS        2
`define CSP_SY_A1        3
`define CSP_SY_A0        4

// change flag positions
`define CSP_FL_LOCK      0
`define CSP_FL_LOS0      1

// reset values
`define CSP_RST_FLAGS    4'h0
`define CSP_RST_BYTE     8'h00
`define CSP_RST_SYNC     5'h00

// stages of the byte toggle path from the serial domain
`define CSP_TGL_STAGES   5
`endif

// ==== csp_pkg.sv ====
// types shared by the control and status pin block
`default_nettype none
package csp_pkg;
	typedef enum logic {CSP_PH_CMD, CSP_PH_DATA} csp_phase_t;
	typedef logic [3:0] csp_flags_t;
	typedef logic [7:0] csp_byte_t;
endpackage : csp_pkg
`default_nettype wire

// ==== csp_link_if.sv ====
// carrier between the system side and the serial shifter
`default_nettype none
interface csp_link_if;
	logic                link_rst_b;  // frame reset, low outside an spi frame
	logic                three_wire;  // data out on the shared data pin
	csp_pkg::csp_byte_t  status_snap; // frozen status byte for reads
	logic                sdi;         // serial data pin level
	csp_pkg::csp_byte_t  rx_byte;     // last complete received byte
	logic                rx_tgl;      // toggles per received byte
	logic                so;          // serial out bit
	logic                a1_oe;       // drive the address 1 / data out pin
	logic                sd_oe;       // drive the data pin

	modport sys   (output link_rst_b, output three_wire, output status_snap, output sdi,
	               input rx_byte, input rx_tgl, input so, input a1_oe, input sd_oe);
	modport shift (input link_rst_b, input three_wire, input status_snap, input sdi,
	               output rx_byte, output rx_tgl, output so, output a1_oe, output sd_oe);
endinterface : csp_link_if
`default_nettype wire

// ==== csp_shifter.sv ====
// serial byte shifter running on the host serial clock
`include "csp_defs.svh"
`default_nettype none
module csp_shifter
(
	// serial clock from the host
	input  wire logic  clk_serial_i,
	// link to the system side
	csp_link_if.shift  lnk
);
	import csp_pkg::*;

	typedef struct packed {
		logic [2:0] bits;
		csp_byte_t  sh;
		csp_byte_t  rx_byte;
		logic       rx_tgl;
		csp_phase_t phase;
		logic       rd;
		csp_byte_t  tx;
		logic       so;
		logic       a1_oe;
		logic       sd_oe;
	} csp_sh_state_t;

	csp_sh_state_t q;
	csp_sh_state_t d;
	csp_byte_t     nxt_byte;

	// shift in every rising edge, decode the command byte, shift out read data
	always_comb
	begin
		d = q;
		nxt_byte = {q.sh[6:0], lnk.sdi};
		d.sh = nxt_byte;
		d.bits = q.bits + 3'h1;
		if (q.rd)
		begin
			d.so = q.tx[7];
			d.tx = {q.tx[6:0], 1'b0};
		end
		if (q.bits == 3'h7)
		begin
			d.rx_byte = nxt_byte;
			d.rx_tgl = ~q.rx_tgl;
			if (q.phase == CSP_PH_CMD)
			begin
				d.phase = CSP_PH_DATA;
				if (nxt_byte == `CSP_CMD_READ)
				begin
					d.rd = 1'b1;
					d.so = lnk.status_snap[7];
					d.tx = {lnk.status_snap[6:0], 1'b0};
					d.a1_oe = ~lnk.three_wire;
					d.sd_oe = lnk.three_wire;
				end
			end
			else
			begin
				d.rd = 1'b0;                              // one byte per read
				d.a1_oe = 1'b0;
				d.sd_oe = 1'b0;
			end
		end
	end

	// frame reset holds everything idle while chip select is high
	always_ff @(posedge clk_serial_i or negedge lnk.link_rst_b)
	begin
		if (!lnk.link_rst_b)
			q <= '0;
		else
			q <= d;
	end

	assign lnk.rx_byte = q.rx_byte;
	assign lnk.rx_tgl  = q.rx_tgl;
	assign lnk.so      = q.so;
	assign lnk.a1_oe   = q.a1_oe;
	assign lnk.sd_oe   = q.sd_oe;

	AST_SH_OE_4W: assert property (@(posedge clk_serial_i) disable iff (!lnk.link_rst_b)
		(q.phase == CSP_PH_CMD && q.bits == 3'h7 && nxt_byte == `CSP_CMD_READ && !lnk.three_wire)
		|=> lnk.a1_oe [*8])
		else $error("data out pin not driven for the read byte");
	AST_SH_BYTE: assert property (@(posedge clk_serial_i) disable iff (!lnk.link_rst_b)
		(q.bits == 3'h7) |=> (lnk.rx_tgl != $past(lnk.rx_tgl)) && (q.bits == 3'h0))
		else $error("byte not closed after eight serial edges");
	COV_SH_READ: cover property (@(posedge clk_serial_i) disable iff (!lnk.link_rst_b)
		q.rd ##8 !q.rd);
endmodule : csp_shifter
`default_nettype wire

// ==== csp_top.sv ====
// control and status pins: serial pin roles, status outputs, reset and output disable
`include "csp_defs.svh"
`default_nettype none
module csp_top
	import csp_pkg::*;
(
	// system clock and the device reset pin
	input  wire logic                clk_sys_i,
	input  wire logic                rst_b_i,
	// host serial clock
	input  wire logic                clk_serial_i,
	// serial interface pins
	input  wire logic                serial_mode_select_i,
	input  wire logic                addr_bit0_or_chip_select_n_i,
	input  wire logic                addr_bit1_or_serial_out_i,
	output logic                     addr_bit1_or_serial_out_o,
	output logic                     addr_bit1_or_serial_out_oe_o,
	input  wire logic                serial_data_i,
	output logic                     serial_data_o,
	output logic                     serial_data_oe_o,
	// configuration
	input  wire logic                spi_three_wire_i,
	// device core status, same clock
	input  wire logic                pll_locked_i,
	input  wire logic [2:0]          input_lost_i,
	// control pin
	input  wire logic                output_disable_i,
	// status pins
	output logic                     status_change_irq_n_o,
	output logic                     pll_lock_indicator_o,
	output logic                     input0_signal_lost_n_o,
	output logic                     input1_signal_lost_n_o,
	output logic                     input2_signal_lost_n_o,
	// towards the device core
	output logic                     clk_out_en_o,
	output logic [1:0]               i2c_addr_o,
	output csp_pkg::csp_flags_t      status_flags_o
);
	import csp_pkg::*;

	typedef struct packed {
		logic [4:0]                  sy1;
		logic [4:0]                  sy2;
		logic [`CSP_TGL_STAGES-1:0]  tgl;
		logic                        i2c_mode;
		logic                        link_en;
		logic                        three_wire;
		logic [1:0]                  addr;
		csp_byte_t                   snap;
		logic                        prev_lock;
		logic [2:0]                  prev_lost;
		csp_flags_t                  flags;
		csp_phase_t                  phase;
		logic                        clear_next;
		logic                        clk_out_en;
		logic                        irq_n;
		logic                        lock_ind;
		logic [2:0]                  los_n;
	} csp_state_t;

	csp_state_t  q;
	csp_state_t  d;
	csp_link_if  lnk ();
	logic        cs_high;
	logic        rx_evt;
	csp_flags_t  chg;
	csp_flags_t  clr;

	// status changes seen this cycle, one flag per monitored condition
	assign chg = {input_lost_i != q.prev_lost ? (input_lost_i ^ q.prev_lost) : 3'h0,
	              pll_locked_i != q.prev_lock};
	assign cs_high = q.sy2[`CSP_SY_CS];
	assign rx_evt = (q.tgl[`CSP_TGL_STAGES-1] != q.tgl[`CSP_TGL_STAGES-2]) && !cs_high;

	// system side next state
	always_comb
	begin
		d = q;
		clr = '0;
		// two flip-flop synchronisers for the pins
		d.sy1 = {addr_bit0_or_chip_select_n_i, addr_bit1_or_serial_out_i,
		         addr_bit0_or_chip_select_n_i, output_disable_i, serial_mode_select_i};
		d.sy2 = q.sy1;
		d.tgl = {q.tgl[`CSP_TGL_STAGES-2:0], lnk.rx_tgl};
		// mode and wiring only change outside a frame
		if (cs_high)
		begin
			d.i2c_mode = (q.sy2[`CSP_SY_MODE] == `CSP_MODE_I2C);
			d.link_en = (q.sy2[`CSP_SY_MODE] != `CSP_MODE_I2C);
			d.three_wire = spi_three_wire_i;
			d.snap = {q.flags, ~q.los_n, q.lock_ind};
			d.phase = CSP_PH_CMD;
			d.clear_next = 1'b0;
		end
		// address straps follow the pins in i2c mode
		if (q.i2c_mode)
		begin
			d.addr[1] = q.sy2[`CSP_SY_A1];
			d.addr[0] = q.sy2[`CSP_SY_A0];
		end
		// command decode of bytes received from the host
		if (rx_evt)
		begin
			if (q.phase == CSP_PH_CMD)
			begin
				d.phase = CSP_PH_DATA;
				d.clear_next = (lnk.rx_byte == `CSP_CMD_CLEAR);
			end
			else if (q.clear_next)
			begin
				clr = lnk.rx_byte[3:0];
				d.clear_next = 1'b0;
			end
		end
		// sticky change flags, a new change wins over a clear
		d.flags = (q.flags & ~clr) | chg;
		d.prev_lock = pll_locked_i;
		d.prev_lost = input_lost_i;
		d.irq_n = ~|d.flags;
		d.lock_ind = pll_locked_i;
		d.los_n = ~input_lost_i;
		d.clk_out_en = ~q.sy2[`CSP_SY_DIS];
	end

	// reset pin loads every register with its default
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			q <= '0;
			q.sy1 <= `CSP_RST_SYNC;
			q.sy2 <= `CSP_RST_SYNC;
			q.flags <= `CSP_RST_FLAGS;
			q.snap <= `CSP_RST_BYTE;
			q.phase <= CSP_PH_CMD;
			q.irq_n <= 1'b1;
			q.los_n <= 3'h7;
			q.clk_out_en <= 1'b0;
		end
		else
			q <= d;
	end

	// frame reset: no serial activity unless spi, selected and out of reset
	assign lnk.link_rst_b = rst_b_i & q.link_en & ~addr_bit0_or_chip_select_n_i;
	assign lnk.three_wire = q.three_wire;
	assign lnk.status_snap = q.snap;
	assign lnk.sdi = serial_data_i;

	// serial shifter on the host clock
	csp_shifter u_shifter
	(
		.clk_serial_i (clk_serial_i),
		.lnk          (lnk.shift)
	);

	// pin and status outputs, all from flip-flops
	assign addr_bit1_or_serial_out_o    = lnk.so;
	assign addr_bit1_or_serial_out_oe_o = lnk.a1_oe;
	assign serial_data_o                = lnk.so;
	assign serial_data_oe_o             = lnk.sd_oe;
	assign status_change_irq_n_o        = q.irq_n;
	assign pll_lock_indicator_o         = q.lock_ind;
	assign input0_signal_lost_n_o       = q.los_n[0];
	assign input1_signal_lost_n_o       = q.los_n[1];
	assign input2_signal_lost_n_o       = q.los_n[2];
	assign clk_out_en_o                 = q.clk_out_en;
	assign i2c_addr_o                   = q.addr;
	assign status_flags_o               = q.flags;

	// checks on the system side
	AST_OUT_DISABLE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		$rose(q.sy2[`CSP_SY_DIS]) |=> !clk_out_en_o [*1] ##0 !clk_out_en_o)
		else $error("outputs not disabled one cycle after disable");
	AST_OUT_ENABLE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!output_disable_i [*3] |=> clk_out_en_o)
		else $error("outputs not enabled with disable low");
	AST_RESET_OFF: assert property (@(posedge clk_sys_i)
		$rose(rst_b_i) |-> !clk_out_en_o)
		else $error("clock outputs enabled during reset");
	AST_LOCK_PIN: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		pll_locked_i |=> pll_lock_indicator_o)
		else $error("lock indicator not high while locked");
	AST_LOS_PIN: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		input_lost_i[0] |=> !input0_signal_lost_n_o && (input2_signal_lost_n_o == !$past(input_lost_i[2])))
		else $error("signal lost pin does not follow the input");
	AST_IRQ_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		$changed(pll_locked_i) ##1 1'b1 |=> !status_change_irq_n_o)
		else $error("interrupt not asserted after a status change");
	AST_IRQ_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(!status_change_irq_n_o && !rx_evt) |=> !status_change_irq_n_o)
		else $error("interrupt released without a clear");
	AST_IRQ_FREE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(q.flags == 4'h0 && chg == 4'h0) |=> status_change_irq_n_o)
		else $error("interrupt low with no change flags");
	AST_I2C_ADDR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(q.i2c_mode && $stable(q.sy2)) |=> i2c_addr_o == {$past(q.sy2[`CSP_SY_A1]), $past(q.sy2[`CSP_SY_A0])})
		else $error("i2c address does not follow the pins");
	AST_I2C_NODRV: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		q.i2c_mode |-> !addr_bit1_or_serial_out_oe_o && !serial_data_oe_o)
		else $error("serial pins driven in i2c mode");
	AST_CS_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		cs_high [*2] |-> !rx_evt && q.phase == CSP_PH_CMD)
		else $error("traffic taken while deselected");

	COV_IRQ_CYCLE: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!status_change_irq_n_o ##[1:400] status_change_irq_n_o);
	COV_CLEAR: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		rx_evt && q.clear_next);
	COV_DISABLE: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		clk_out_en_o ##1 !clk_out_en_o);
endmodule : csp_top
`default_nettype wire

// ==== csp_host_model.sv ====
// host controller model: spi master on the shared serial pins
`default_nettype none
module csp_host_model
(
	// serial pins towards the device
	output var logic  sclk_o,
	output var logic  cs_n_o,
	output var logic  sdi_o,
	input  wire logic sdo_i
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle: serial clock stands still low, device deselected
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o  = 1'b0;
	end

	// one frame: command byte then data byte, msb first; read bits caught on falling edges
	task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] rx);
		logic [15:0] sh;
		sh = {cmd, dat};
		rx = 8'h00;
		cs_n_o = 1'b0;
		#300;
		for (int i = 0; i < 16; i++)
		begin
			sdi_o = sh[15 - i];
			#62.5 sclk_o = 1'b1;
			#62.5 sclk_o = 1'b0;
			if (i >= 7 && i < 15)
				rx = {rx[6:0], sdo_i};
		end
		// released data line shows no stale bit
		sdi_o = ~sdi_o;
		// chip select held past the last edge, then a gap between frames
		#300 cs_n_o = 1'b1;
		#300;
	endtask
endmodule // csp_host_model
`default_nettype wire

// ==== csp_top_bench.sv ====
// self-checking bench for the control and status pin block
`include "csp_defs.svh"
`default_nettype none
module csp_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import csp_pkg::*;

	typedef struct packed {logic lk; logic [2:0] ls; logic [3:0] exp;} csp_row_t;
	// core status in, {los2, los1, los0, lock} pins expected
	localparam csp_row_t ROWS [4] = '{'{1'b1, 3'h0, 4'hf}, '{1'b1, 3'h5, 4'h5},
		'{1'b0, 3'h2, 4'ha}, '{1'b0, 3'h7, 4'h0}};

	logic        clk_sys_i = 1'b0;
	logic        rst_b_i   = 1'b0;
	logic        mode      = 1'b0;
	logic        a0        = 1'b1;
	logic        a1        = 1'b0;
	logic        three     = 1'b0;
	logic        locked    = 1'b0;
	logic [2:0]  lost      = 3'h0;
	logic        dis       = 1'b0;
	logic        sclk, cs_n, hsdi, a1_o, a1_oe, sd_o, sd_oe, irq_n, lock, los0, los1, los2, en;
	logic [1:0]  addr;
	csp_flags_t  flags;
	csp_byte_t   rx;
	int          fail_count = 0;
	int          n_tests    = 0;
	int          cyc        = 0;

	// pin levels from every party's enables
	wire a1_pin = a1_oe ? a1_o : a1;
	wire sd_pin = sd_oe ? sd_o : hsdi;
	wire cs_pin = mode ? a0 : cs_n;
	wire sdo    = three ? sd_pin : a1_pin;

	always #12.5 clk_sys_i = ~clk_sys_i;

	csp_top i_csp_top (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .clk_serial_i(sclk),
		.serial_mode_select_i(mode), .addr_bit0_or_chip_select_n_i(cs_pin),
		.addr_bit1_or_serial_out_i(a1_pin), .addr_bit1_or_serial_out_o(a1_o),
		.addr_bit1_or_serial_out_oe_o(a1_oe), .serial_data_i(sd_pin), .serial_data_o(sd_o),
		.serial_data_oe_o(sd_oe), .spi_three_wire_i(three), .pll_locked_i(locked),
		.input_lost_i(lost), .output_disable_i(dis), .status_change_irq_n_o(irq_n),
		.pll_lock_indicator_o(lock), .input0_signal_lost_n_o(los0),
		.input1_signal_lost_n_o(los1), .input2_signal_lost_n_o(los2), .clk_out_en_o(en),
		.i2c_addr_o(addr), .status_flags_o(flags));

	csp_host_model i_csp_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(hsdi), .sdo_i(sdo));

	// compare one value and count it
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// counts, verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// cut a hang short
	always @(posedge clk_sys_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			report_and_stop();
		end
	end

	// main sequence
	initial
	begin
		repeat (10) @(posedge clk_sys_i);
		check("pins in reset", {irq_n, lock, los2, los1, los0, en}, 8'h2e);
		repeat (2) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		foreach (ROWS[k])
		begin
			@(posedge clk_sys_i);
			locked <= ROWS[k].lk;
			lost   <= ROWS[k].ls;
			repeat (3) @(posedge clk_sys_i);
			check("status pins", {los2, los1, los0, lock}, ROWS[k].exp);
			check("irq on change", irq_n, 1'b0);
		end
		$display("test status rows done");
		dis <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		check("outputs disabled", en, 1'b0);
		dis <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		check("outputs enabled", en, 1'b1);
		$display("test output disable done");
		mode <= `CSP_MODE_I2C;
		repeat (8) @(posedge clk_sys_i);
		check("i2c address a", addr, 2'h1);
		check("pins not driven", {a1_oe, sd_oe}, 2'h0);
		a0 <= 1'b0;
		a1 <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		check("i2c address b", addr, 2'h2);
		$display("test i2c straps done");
		mode <= ~`CSP_MODE_I2C;
		repeat (10) @(posedge clk_sys_i);
		i_csp_host_model.frame(`CSP_CMD_CLEAR, 8'h0f, rx);
		repeat (12) @(posedge clk_sys_i);
		check("flags cleared", flags, 4'h0);
		check("irq released", irq_n, 1'b1);
		i_csp_host_model.frame(`CSP_CMD_READ, 8'h00, rx);
		check("four wire read", rx, 8'h0e);
		$display("test spi four wire done");
		three  <= 1'b1;
		locked <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		check("irq on lock", irq_n, 1'b0);
		i_csp_host_model.frame(`CSP_CMD_READ, 8'h00, rx);
		check("three wire read", rx, 8'h1f);
		check("irq held", irq_n, 1'b0);
		$display("test spi three wire done");
		rst_b_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		check("flags in reset", flags, 4'h0);
		check("enable in reset", en, 1'b0);
		rst_b_i <= 1'b1;
		// disable pin is low, so the outputs come back after release
		repeat (3) @(posedge clk_sys_i);
		check("enable after reset", en, 1'b1);
		$display("test second reset done");
		report_and_stop();
	end
endmodule // csp_top_bench
`default_nettype wire
